// *** hw/l2cb_ctl.sv ***
`timescale 1ns/1ps
`include "l2cb_consts.svh"
module l2cb_ctl (
    input  wire logic  clock,              // 100 MHz system clock
    input  wire logic  rst,                // Asynchronous reset, active high
    input  wire logic  cpu_addr_strobe_n,  // Processor address strobe
    input  wire logic  cpu_cache_n,        // Processor wants the line cached
    input  wire logic  cpu_data,           // High for data, low for code
    input  wire logic  cpu_write,          // High for a write cycle
    input  wire logic  mem_cacheable_n,    // Memory controller: cacheable
    input  wire logic  mem_read_only_n,    // Memory controller: read-only
    input  wire logic  membus_active,      // A memory-bus cycle is running
    input  wire logic  tag_valid,          // Tag lookup result present
    input  wire logic  tag_hit,            // Lookup hit (with tag_valid)
    input  wire logic  next_addr_req_n,    // Next address from memory ctl
    input  wire logic  mem_cycle_done_n,   // Memory cycle complete
    input  wire logic  cache_ready_req,    // Request one cache transfer
    input  wire logic  inquire_hit_mod,    // Inquire hit a modified line
    input  wire logic  cycle_stuck,        // Outstanding cycle cannot finish
    output logic [2:0] beats_left,         // Transfers left in burst
    l2cb_link_if.ctl   link                // Link to processor and chips
);

    // Cycle and latch state, registered outputs and their next values
    l2cb_pkg::l2cb_xfer_t  xfer;
    l2cb_pkg::l2cb_xfer_t  next_xfer;
    l2cb_pkg::l2cb_latch_t latch;
    l2cb_pkg::l2cb_latch_t next_latch;
    logic [2:0]            next_beats_left;
    logic                  ready_n;
    logic                  next_ready_n;
    logic                  final_n;
    logic                  next_final_n;
    logic                  abort_n;
    logic                  next_abort_n;
    logic                  latch_n;
    logic                  next_latch_n;
    logic                  strobe;
    logic                  bus_step;

    // Beats of a cycle: a line when the processor caches and, for reads, the memory side agrees; a
    // read-only region only bursts for code fetches or writebacks.
    function automatic logic [2:0] cycle_beats(
        input logic cache_n, input logic data, input logic mkc_n,
        input logic ro_n, input logic wr);
        logic burst;
        // Writes burst whenever the processor caches them; reads also need
        // the memory side to agree, and read-only lines only for code
        burst = !cache_n && (wr || (!mkc_n && (ro_n || !data)));
        cycle_beats = burst ? `L2CB_LINE_BEATS : `L2CB_SINGLE_BEATS;
    endfunction : cycle_beats

    // Strobe and bus step are same-clock levels, sampled at each edge
    assign strobe   = !cpu_addr_strobe_n;
    assign bus_step = !next_addr_req_n || !mem_cycle_done_n;

    // Burst counting; ready and last leave together from flops.
    // The length is fixed at the first request of a cycle from the inputs
    // present then; later changes of those inputs do not stretch or cut a
    // burst already running. beats_left counts what is still to come, so
    // last rides on the ready that brings it to zero.
    always_comb begin
        next_xfer       = xfer;
        next_beats_left = beats_left;
        next_ready_n    = 1'b1;
        next_final_n    = 1'b1;
        if (!abort_n) begin
            // Aborted cycle: forget the burst in progress
            next_xfer       = l2cb_pkg::L2CB_XF_IDLE;
            next_beats_left = 3'h0;
        end else if (cache_ready_req) begin
            next_ready_n = 1'b0;
            unique case (xfer)
                l2cb_pkg::L2CB_XF_IDLE: begin
                    next_beats_left = cycle_beats(cpu_cache_n, cpu_data,
                        mem_cacheable_n, mem_read_only_n, cpu_write) - 3'h1;
                    if (next_beats_left == 3'h0) begin
                        next_final_n = 1'b0;
                    end else begin
                        next_xfer = l2cb_pkg::L2CB_XF_BURST;
                    end
                end
                l2cb_pkg::L2CB_XF_BURST: begin
                    next_beats_left = beats_left - 3'h1;
                    if (beats_left == 3'h1) begin
                        next_final_n = 1'b0;
                        next_xfer    = l2cb_pkg::L2CB_XF_IDLE;
                    end
                end
                default: begin
                    // Not a one-hot code: drop the cycle
                    next_xfer       = l2cb_pkg::L2CB_XF_IDLE;
                    next_beats_left = 3'h0;
                    next_ready_n    = 1'b1;
                end
            endcase
        end
    end

    // Cycle state; reset leaves ready and last idle
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            xfer       <= l2cb_pkg::L2CB_XF_IDLE;
            beats_left <= 3'h0;
            ready_n    <= 1'b1;
            final_n    <= 1'b1;
        end else begin
            xfer       <= next_xfer;
            beats_left <= next_beats_left;
            ready_n    <= next_ready_n;
            final_n    <= next_final_n;
        end
    end

    // Byte-enable latch control. The memory bus keeps what is held, so an
    // abort only drops a cycle still waiting for its capture.
    //   OPEN  - enable low, chips follow the processor byte enables
    //   HOLD  - enable high, held value drives the memory bus
    //   PEND  - enable high, a new cycle waits for the bus to step on
    //   PULSE - enable low for exactly one clock to take the new enables
    // A hit in HOLD returns to OPEN at once, so the enable may stand high for a
    // single clock. Leaving OPEN on the strobe itself matters: the enables
    // the chips took at that edge are the ones of the new cycle, and one
    // more open clock would overwrite them with whatever follows.
    // The enable is decoded from the next state and registered, so both
    // enable pins leave one flop together and never glitch.
    always_comb begin
        next_latch = latch;
        unique case (latch)
            l2cb_pkg::L2CB_LE_OPEN: begin
                if (strobe) begin
                    next_latch = membus_active ? l2cb_pkg::L2CB_LE_PEND
                                               : l2cb_pkg::L2CB_LE_HOLD;
                end
            end
            l2cb_pkg::L2CB_LE_HOLD: begin
                if (tag_valid && tag_hit) begin
                    next_latch = l2cb_pkg::L2CB_LE_OPEN;
                end else if (strobe && membus_active) begin
                    next_latch = l2cb_pkg::L2CB_LE_PEND;
                end else if (!mem_cycle_done_n) begin
                    next_latch = l2cb_pkg::L2CB_LE_OPEN;
                end
            end
            l2cb_pkg::L2CB_LE_PEND: begin
                // Abort or hit: this cycle never takes the memory bus
                if (!abort_n || (tag_valid && tag_hit)) begin
                    next_latch = l2cb_pkg::L2CB_LE_HOLD;
                end else if (bus_step) begin
                    next_latch = l2cb_pkg::L2CB_LE_PULSE;
                end
            end
            l2cb_pkg::L2CB_LE_PULSE: begin
                next_latch = l2cb_pkg::L2CB_LE_HOLD;
            end
            default: begin
                next_latch = l2cb_pkg::L2CB_LE_OPEN;
            end
        endcase
        next_latch_n = !((next_latch == l2cb_pkg::L2CB_LE_OPEN)
                      || (next_latch == l2cb_pkg::L2CB_LE_PULSE));
    end

    // Latch state; reset opens the latch
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            latch   <= l2cb_pkg::L2CB_LE_OPEN;
            latch_n <= 1'b0;
        end else begin
            latch   <= next_latch;
            latch_n <= next_latch_n;
        end
    end

    // Back-off: only for the inquire deadlock, never two clocks running.
    // The deadlock needs both halves at once: the processor holds the bus
    // for a cycle that cannot end, and the inquire must write a modified
    // line back over that same bus. Either half alone just waits.
    // Gating on the current abort keeps each pulse one clock wide even if
    // the condition stays up; a fresh back-off follows two clocks later,
    // which is the minimum spacing.
    always_comb begin
        next_abort_n = 1'b1;
        if (inquire_hit_mod && cycle_stuck) begin
            next_abort_n = !abort_n;
        end
    end

    // Back-off flop; reset leaves it idle
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            abort_n <= 1'b1;
        end else begin
            abort_n <= next_abort_n;
        end
    end

    // All link outputs straight from flops. Both latch enables share one
    // flop on purpose: a second copy could split by a clock after reset
    // or a state upset, which the chips and an external latch would see
    // as different captures.
    assign link.cache_xfer_ready_n   = ready_n;
    assign link.burst_final_n        = final_n;
    assign link.sram_byte_latch_en_n = latch_n;
    assign link.ext_byte_latch_en_n  = latch_n;
    assign link.cpu_abort_n          = abort_n;

endmodule : l2cb_ctl

// *** hw/l2cb_consts.svh ***
`ifndef L2CB_CONSTS_SVH
`define L2CB_CONSTS_SVH

`define L2CB_BE_LANES      8
`define L2CB_LINE_BEATS    3'h4
`define L2CB_SINGLE_BEATS  3'h1
`define L2CB_ABORT_CLKS    1

`endif

// *** hw/l2cb_pkg.sv ***
package l2cb_pkg;

    // Burst tracking in the controller
    typedef enum logic [1:0] {
        L2CB_XF_IDLE  = 2'b01,
        L2CB_XF_BURST = 2'b10
    } l2cb_xfer_t;

    // Byte-enable latch control; only OPEN and PULSE drive the enable low
    typedef enum logic [3:0] {
        L2CB_LE_OPEN  = 4'b0001,
        L2CB_LE_HOLD  = 4'b0010,
        L2CB_LE_PEND  = 4'b0100,
        L2CB_LE_PULSE = 4'b1000
    } l2cb_latch_t;

endpackage : l2cb_pkg

// *** hw/l2cb_link_if.sv ***
`timescale 1ns/1ps
interface l2cb_link_if;
    logic burst_final_n;        // Final cache ready of the cycle
    logic cache_xfer_ready_n;   // Cache burst ready
    logic sram_byte_latch_en_n; // Byte-enable latch enable to cache chips
    logic ext_byte_latch_en_n;  // Same, for an external latch
    logic cpu_abort_n;          // One-clock back-off

    modport ctl (
        output burst_final_n, cache_xfer_ready_n, sram_byte_latch_en_n,
        output ext_byte_latch_en_n, cpu_abort_n
    );
    modport far (
        input burst_final_n, cache_xfer_ready_n, sram_byte_latch_en_n,
        input ext_byte_latch_en_n, cpu_abort_n
    );
endinterface : l2cb_link_if

// *** hw/l2cb_far.sv ***
`timescale 1ns/1ps
`include "l2cb_consts.svh"
module l2cb_far #(
    parameter int LANES = `L2CB_BE_LANES  // Chips holding byte enables
) (
    input  wire logic             clock,           // 100 MHz system clock
    input  wire logic             rst,             // Asynchronous reset, active high
    input  wire logic [LANES-1:0] cpu_byte_en_n,   // Processor byte enables
    l2cb_link_if.far              link,            // Link from the controller
    output logic [LANES-1:0]      membus_byte_en_n, // Held byte enables
    output logic                  membus_be_oe,    // High while held value driven
    output logic [2:0]            beat_count,      // Transfers seen this cycle
    output logic                  cycle_done,      // Pulse: final transfer seen
    output logic                  cpu_bus_oe       // Low once cycle abandoned
);

    logic [LANES-1:0] next_membus_byte_en_n;
    logic [2:0]       next_beat_count;
    logic             next_cycle_done;
    logic             next_cpu_bus_oe;

    // One latch per chip; captures on each edge while enable is low
    always_comb begin
        next_membus_byte_en_n = membus_byte_en_n;
        if (!link.sram_byte_latch_en_n) begin
            next_membus_byte_en_n = cpu_byte_en_n;
        end
    end

    // Held bytes go to the memory bus only while the latch is closed
    assign membus_be_oe = link.sram_byte_latch_en_n;

    // Beat tracking; an abort wipes the cycle but not the held enables
    always_comb begin
        next_beat_count = beat_count;
        next_cycle_done = 1'b0;
        next_cpu_bus_oe = cpu_bus_oe;
        if (!link.cpu_abort_n) begin
            next_beat_count = 3'h0;
            next_cpu_bus_oe = 1'b0;
        end else if (!link.cache_xfer_ready_n) begin
            next_cpu_bus_oe = 1'b1;
            if (!link.burst_final_n) begin
                next_beat_count = 3'h0;
                next_cycle_done = 1'b1;
            end else begin
                next_beat_count = beat_count + 3'h1;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            membus_byte_en_n <= '1;
            beat_count       <= 3'h0;
            cycle_done       <= 1'b0;
            cpu_bus_oe       <= 1'b1;
        end else begin
            membus_byte_en_n <= next_membus_byte_en_n;
            beat_count       <= next_beat_count;
            cycle_done       <= next_cycle_done;
            cpu_bus_oe       <= next_cpu_bus_oe;
        end
    end

endmodule : l2cb_far

// *** test/l2cb_link_sva.sv ***
`timescale 1ns/1ps
module l2cb_link_sva (
    input wire logic clock,                // System clock
    input wire logic rst,                  // Async reset
    input wire logic burst_final_n,        // Last cache ready
    input wire logic cache_xfer_ready_n,   // Cache ready
    input wire logic sram_byte_latch_en_n, // Chip latch enable
    input wire logic ext_byte_latch_en_n,  // External latch enable
    input wire logic cpu_abort_n           // Back-off
);
    // One clock domain, so clocking and disable are given once
    default clocking @(posedge clock);
    endclocking
    default disable iff (rst);

    // Both enables come from one state, so any split is a fault
    a_latch_en_mirror: assert property (
        ext_byte_latch_en_n == sram_byte_latch_en_n) else $error("latch enables differ");
    a_latch_en_moves: assert property (
        $changed(sram_byte_latch_en_n) |-> $changed(ext_byte_latch_en_n))
        else $error("external enable lags");
    a_last_with_ready: assert property (
        !burst_final_n |-> !cache_xfer_ready_n) else $error("last without ready");
    a_abort_one_clk: assert property (
        $fell(cpu_abort_n) |=> cpu_abort_n) else $error("abort longer than one clock");
    a_abort_drops_ready: assert property (
        !cpu_abort_n |=> cache_xfer_ready_n) else $error("ready after abort");
    a_abort_drops_last: assert property (
        !cpu_abort_n |=> burst_final_n) else $error("last after abort");
    a_reset_latch_open: assert property (
        $past(rst) |-> !sram_byte_latch_en_n) else $error("latch closed after reset");
    a_reset_quiet: assert property (
        $past(rst) |-> burst_final_n && cpu_abort_n && cache_xfer_ready_n)
        else $error("strobe active after reset");

    // Main scenarios reached
    cover property (!burst_final_n && !$past(cache_xfer_ready_n));
    cover property ($fell(cpu_abort_n));
    cover property ($rose(sram_byte_latch_en_n));
endmodule : l2cb_link_sva

// *** test/l2_cpu_side_burst_latch_backoff_ctl_tb.sv ***
`timescale 1ns/1ps
module l2_cpu_side_burst_latch_backoff_ctl_tb;
    logic       clock             = 1'b0;
    logic       rst               = 1'b1;
    logic       cpu_addr_strobe_n = 1'b1;
    logic       cpu_cache_n       = 1'b1;
    logic       cpu_data          = 1'b0;
    logic       cpu_write         = 1'b0;
    logic       mem_cacheable_n   = 1'b1;
    logic       mem_read_only_n   = 1'b1;
    logic       membus_active     = 1'b0;
    logic       tag_valid         = 1'b0;
    logic       tag_hit           = 1'b0;
    logic       next_addr_req_n   = 1'b1;
    logic       mem_cycle_done_n  = 1'b1;
    logic       cache_ready_req   = 1'b0;
    logic       inquire_hit_mod   = 1'b0;
    logic       cycle_stuck       = 1'b0;
    logic [7:0] cpu_byte_en_n     = 8'hff;
    logic [2:0] beats_left;
    logic [7:0] membus_byte_en_n;
    logic       membus_be_oe;
    logic [2:0] beat_count;
    logic       cycle_done;
    logic       cpu_bus_oe;
    int         errors            = 0;
    int         num_checks        = 0;

    // Free-running 100 MHz clock
    always #5 clock = ~clock;

    l2cb_link_if link ();
    l2cb_ctl u_l2cb_ctl (.clock, .rst, .cpu_addr_strobe_n, .cpu_cache_n, .cpu_data,
        .cpu_write, .mem_cacheable_n, .mem_read_only_n, .membus_active, .tag_valid,
        .tag_hit, .next_addr_req_n, .mem_cycle_done_n, .cache_ready_req,
        .inquire_hit_mod, .cycle_stuck, .beats_left, .link);
    l2cb_far u_l2cb_far (.clock, .rst, .cpu_byte_en_n, .link, .membus_byte_en_n,
        .membus_be_oe, .beat_count, .cycle_done, .cpu_bus_oe);
    l2cb_link_sva u_l2cb_link_sva (.clock, .rst,
        .burst_final_n(link.burst_final_n), .cache_xfer_ready_n(link.cache_xfer_ready_n),
        .sram_byte_latch_en_n(link.sram_byte_latch_en_n),
        .ext_byte_latch_en_n(link.ext_byte_latch_en_n), .cpu_abort_n(link.cpu_abort_n));

    // Inputs move on the falling edge, well away from sampling
    task automatic tick();
        @(negedge clock);
    endtask : tick

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic end_sim();
        if (errors == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_sim

    // One processor cycle, transfers requested back to back
    task automatic xfer(input logic [4:0] m);
        int n;
        n = (!m[4] && (m[2] || (!m[1] && (m[0] || !m[3])))) ? 4 : 1;
        {cpu_cache_n, cpu_data, cpu_write, mem_cacheable_n, mem_read_only_n} = m;
        cache_ready_req = 1'b1;
        for (int k = 0; k < n; k++) begin
            tick();
            if (k == n - 1) begin
                cache_ready_req = 1'b0;
            end
            chk("ready", 8'h00, link.cache_xfer_ready_n);
            chk("last", (k == n - 1) ? 8'h00 : 8'h01, link.burst_final_n);
            chk("left", 8'(n - 1 - k), beats_left);
        end
        tick();
        chk("done", 8'h01, cycle_done);
    endtask : xfer

    // Reset, length decode, latch control, back-off
    initial begin
        repeat (8) tick();
        rst = 1'b0;
        tick();
        chk("latch", 8'h00, link.sram_byte_latch_en_n);
        chk("abort", 8'h01, link.cpu_abort_n);
        chk("mbe", 8'hff, membus_byte_en_n);
        for (int i = 0; i < 32; i++) begin
            xfer(i[4:0]);
        end
        cpu_byte_en_n = 8'h5a;
        cpu_addr_strobe_n = 1'b0;
        tick();
        cpu_addr_strobe_n = 1'b1;
        cpu_byte_en_n = 8'ha5;
        chk("latch", 8'h01, link.sram_byte_latch_en_n);
        chk("ext", 8'h01, link.ext_byte_latch_en_n);
        tick();
        chk("mbe", 8'h5a, membus_byte_en_n);
        chk("mbe oe", 8'h01, membus_be_oe);
        tag_valid = 1'b1;
        tag_hit = 1'b1;
        tick();
        tag_valid = 1'b0;
        tag_hit = 1'b0;
        chk("latch", 8'h00, link.sram_byte_latch_en_n);
        tick();
        chk("mbe", 8'ha5, membus_byte_en_n);
        // Memory bus busy: capture waits for next address
        membus_active = 1'b1;
        cpu_addr_strobe_n = 1'b0;
        tick();
        cpu_addr_strobe_n = 1'b1;
        cpu_byte_en_n = 8'h3c;
        tick();
        chk("latch", 8'h01, link.sram_byte_latch_en_n);
        next_addr_req_n = 1'b0;
        tick();
        next_addr_req_n = 1'b1;
        chk("latch", 8'h00, link.sram_byte_latch_en_n);
        tick();
        chk("latch", 8'h01, link.sram_byte_latch_en_n);
        chk("mbe", 8'h3c, membus_byte_en_n);
        mem_cycle_done_n = 1'b0;
        tick();
        mem_cycle_done_n = 1'b1;
        membus_active = 1'b0;
        // Deadlock in mid-burst: abort, then a clean restart
        {cpu_cache_n, cpu_data, cpu_write, mem_cacheable_n, mem_read_only_n} = 5'h04;
        cache_ready_req = 1'b1;
        repeat (2) tick();
        inquire_hit_mod = 1'b1;
        cycle_stuck = 1'b1;
        tick();
        cache_ready_req = 1'b0;
        inquire_hit_mod = 1'b0;
        cycle_stuck = 1'b0;
        chk("abort", 8'h00, link.cpu_abort_n);
        tick();
        chk("abort", 8'h01, link.cpu_abort_n);
        chk("ready", 8'h01, link.cache_xfer_ready_n);
        chk("beats", 8'h00, beat_count);
        chk("bus oe", 8'h00, cpu_bus_oe);
        chk("mbe", 8'h3c, membus_byte_en_n);
        xfer(5'h04);
        // Either condition alone is no deadlock
        for (int j = 0; j < 2; j++) begin
            inquire_hit_mod = j[0];
            cycle_stuck = !j[0];
            tick();
            chk("abort", 8'h01, link.cpu_abort_n);
        end
        inquire_hit_mod = 1'b0;
        cycle_stuck = 1'b0;
        tick();
        end_sim();
    end
endmodule : l2_cpu_side_burst_latch_backoff_ctl_tb
